// >>> hw/itvc_top.sv
// Inductive transmitter voltage controller: ping sequencing and setpoint loop
//
// What this block does
// RL1: The commanded inverter supply stays within 3 V to 12 V, lower meaning less power.
// RL2: The setpoint moves in steps of half a millivolt, far finer than 50 mV.
// RL3: The first power signal of a ping is applied with the supply set to 6.5 V.
// RL4: The first ping runs the inverter at 140 kHz.
// RL5: With no signal strength packet after a ping, the power signal is removed.
// RL6: Retries step the frequency down within 105 to 140 kHz until strength is acceptable.
// RL7: During power transfer the loop adjusts the inverter supply voltage.
// RL8: The loop feedback is the coil voltage amplitude in millivolts, finer than 5 mV.
// RL9: Loop uses gain 1, no integral or derivative, output limit 1500, scale -0.5 mV.
// RL10: A user indicator gives distance feedback for placing the receiver.
// RL11: Each step adds the scaled clamped output to the setpoint and saturates it.
`timescale 1ns/1ps
module itvc_top #(
	parameter int PING_WAIT_CYC  = itvc_pkg::PING_WAIT_CYC,
	parameter int REMOVE_OFF_CYC = itvc_pkg::REMOVE_OFF_CYC,
	parameter int MAX_RETRIES    = 8
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        start,
	input  wire logic        stop,
	input  wire logic        ss_valid,
	input  wire logic [7:0]  ss_value,
	input  wire logic        meas_valid,
	input  wire logic [15:0] meas_mv,
	input  wire logic [15:0] target_mv,
	output logic             power_en,
	output logic      [7:0]  freq_khz,
	output logic      [15:0] vset_hmv,
	output logic             transfer,
	output logic             ping_fail,
	output logic      [2:0]  bar_level,
	output logic             aligned
);
	// ----------------------------------------
	// State and counters
	// ----------------------------------------
	itvc_pkg::itvc_state_type state_r;
	itvc_pkg::itvc_state_type state_nxt;

	logic [23:0] tmr_r;
	logic [23:0] tmr_nxt;

	logic [7:0]  freq_r;
	logic [7:0]  freq_nxt;

	logic [7:0]  retry_r;
	logic [7:0]  retry_nxt;

	logic        fail_r;
	logic        fail_nxt;
	logic        power_r;
	logic        power_nxt;
	logic        settle_r;
	logic        settle_nxt;

	logic [15:0] meas_r;
	logic        step_r;
	logic [15:0] target_r;

	// ----------------------------------------
	// Decodes
	// ----------------------------------------
	wire logic        ss_ok;
	wire logic        weak_ss;
	wire logic [23:0] tmr_inc;
	wire logic        wait_done;
	wire logic        off_done;
	wire logic        settle_done;
	wire logic [7:0]  freq_down;
	wire logic        freq_room;
	wire logic        retry_room;
	wire logic [7:0]  retry_inc;
	wire logic        abort_seen;
	wire logic        seq_end;
	wire logic        ping_load;
	wire logic        in_xfer;
	wire logic        ind_en;
	wire logic        step_ok;

	assign ss_ok       = ss_valid && (ss_value >= itvc_pkg::SS_ACCEPT); // see RL6
	// A weak report is handled like a missing one
	assign weak_ss     = ss_valid && !ss_ok; // see RL5

	assign tmr_inc     = tmr_r + 24'h000001;
	assign wait_done   = (tmr_r == 24'(PING_WAIT_CYC - 1));
	assign off_done    = (tmr_r == 24'(REMOVE_OFF_CYC - 1));
	assign settle_done = (tmr_r == 24'(itvc_pkg::SETTLE_CYC - 1));

	assign freq_down   = freq_r - itvc_pkg::F_STEP_KHZ;
	// A retry never runs below the lowest permitted frequency
	assign freq_room   = (freq_r >= (itvc_pkg::F_MIN_KHZ + itvc_pkg::F_STEP_KHZ)); // see RL6
	assign retry_room  = (retry_r < 8'(MAX_RETRIES));
	assign retry_inc   = retry_r + 8'h01;
	assign abort_seen  = (retry_r == 8'h00);
	assign seq_end     = abort_seen || !retry_room || !freq_room; // see RL6

	assign ping_load   = (state_r != itvc_pkg::ST_PING) && (state_nxt == itvc_pkg::ST_PING);
	assign in_xfer     = (state_r == itvc_pkg::ST_TRANSFER);
	assign ind_en      = (state_r == itvc_pkg::ST_WAIT_SS) || in_xfer;
	assign step_ok     = in_xfer && settle_r && meas_valid && !stop; // see RL7

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt  = state_r;
		tmr_nxt    = tmr_inc;
		freq_nxt   = freq_r;
		retry_nxt  = retry_r;
		fail_nxt   = fail_r;
		power_nxt  = power_r;
		settle_nxt = settle_r;
		case (state_r)
			itvc_pkg::ST_IDLE: begin
				power_nxt = 1'b0;
				tmr_nxt   = 24'h000000;
				if (start) begin
					state_nxt = itvc_pkg::ST_PING;
					freq_nxt  = itvc_pkg::F_PING_KHZ; // see RL4
					retry_nxt = 8'h00;
					fail_nxt  = 1'b0;
				end
			end

			itvc_pkg::ST_PING: begin
				// Setpoint is loaded on entry; give the rail one cycle before power
				power_nxt = 1'b1; // see RL3
				tmr_nxt   = 24'h000000;
				state_nxt = itvc_pkg::ST_WAIT_SS;
			end

			itvc_pkg::ST_WAIT_SS: begin
				if (stop) begin
					// An abort also ends the retry run, so removal returns to idle
					state_nxt = itvc_pkg::ST_REMOVE;
					power_nxt = 1'b0;
					tmr_nxt   = 24'h000000;
					retry_nxt = 8'h00;
				end else if (ss_ok) begin
					state_nxt  = itvc_pkg::ST_TRANSFER;
					tmr_nxt    = 24'h000000;
					settle_nxt = 1'b0;
				end else if (weak_ss || wait_done) begin
					// Missing or weak strength report ends this ping
					state_nxt = itvc_pkg::ST_REMOVE; // see RL5
					power_nxt = 1'b0; // see RL5
					tmr_nxt   = 24'h000000;
					retry_nxt = retry_inc;
				end
			end

			itvc_pkg::ST_REMOVE: begin
				power_nxt = 1'b0;
				if (stop) begin
					state_nxt = itvc_pkg::ST_IDLE;
				end else if (off_done) begin
					tmr_nxt = 24'h000000;
					if (seq_end) begin
						state_nxt = abort_seen ? itvc_pkg::ST_IDLE : itvc_pkg::ST_FAIL;
						fail_nxt  = !abort_seen; // see RL6
					end else begin
						state_nxt = itvc_pkg::ST_PING;
						freq_nxt  = freq_down; // see RL6
					end
				end
			end

			itvc_pkg::ST_TRANSFER: begin
				if (settle_done)
					settle_nxt = 1'b1;
				if (settle_r)
					tmr_nxt = tmr_r;
				if (stop) begin
					state_nxt = itvc_pkg::ST_REMOVE;
					power_nxt = 1'b0;
					tmr_nxt   = 24'h000000;
					retry_nxt = 8'h00;
				end
			end

			itvc_pkg::ST_FAIL: begin
				power_nxt = 1'b0;
				tmr_nxt   = 24'h000000;
				if (start) begin
					state_nxt = itvc_pkg::ST_PING;
					freq_nxt  = itvc_pkg::F_PING_KHZ;
					retry_nxt = 8'h00;
					fail_nxt  = 1'b0;
				end
			end

			default: begin
				state_nxt = itvc_pkg::ST_IDLE;
				power_nxt = 1'b0;
				tmr_nxt   = 24'h000000;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	// One small block per register keeps each reset value beside its flop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			state_r <= itvc_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			tmr_r <= 24'h000000;
		else
			tmr_r <= tmr_nxt;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			freq_r <= itvc_pkg::F_PING_KHZ;
		else
			freq_r <= freq_nxt;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			retry_r <= 8'h00;
		else
			retry_r <= retry_nxt;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			fail_r <= 1'b0;
		else
			fail_r <= fail_nxt;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			power_r <= 1'b0;
		else
			power_r <= power_nxt;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			settle_r <= 1'b0;
		else
			settle_r <= settle_nxt;
	end

	// ----------------------------------------
	// Feedback capture
	// ----------------------------------------
	// Samples are ignored until the rail has settled after transfer starts
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			step_r <= 1'b0;
		else
			step_r <= step_ok; // see RL7
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meas_r   <= 16'h0000;
			target_r <= 16'h0000;
		end else if (meas_valid) begin
			meas_r   <= meas_mv; // see RL8
			target_r <= target_mv;
		end
	end

	// ----------------------------------------
	// Loop and indicator
	// ----------------------------------------
	itvc_pid u_pid (
		.clk       (clk),
		.rstn      (rstn),
		.load      (ping_load),
		.step      (step_r),
		.target_mv (target_r),
		.meas_mv   (meas_r),
		.vset      (vset_hmv)
	);

	itvc_align u_align (
		.clk       (clk),
		.rstn      (rstn),
		.enable    (ind_en),
		.ss_valid  (ss_valid),
		.ss_value  (ss_value),
		.bar_level (bar_level),
		.aligned   (aligned)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign power_en  = power_r;
	assign freq_khz  = freq_r;
	assign transfer  = in_xfer;
	assign ping_fail = fail_r;
endmodule

// >>> pkg/itvc_pkg.sv
// Constants shared by the inductive transmitter voltage controller
package itvc_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ          = 250;
	localparam int PING_WAIT_US     = 70;
	localparam int PING_WAIT_CYC    = PING_WAIT_US * CLK_MHZ;
	localparam int REMOVE_OFF_US    = 30;
	localparam int REMOVE_OFF_CYC   = REMOVE_OFF_US * CLK_MHZ;
	localparam int SETTLE_US        = 4;
	localparam int SETTLE_CYC       = SETTLE_US * CLK_MHZ;

	// ----------------------------------------
	// Voltage setpoint, LSB is half a millivolt
	// ----------------------------------------
	localparam int        VW          = 16;
	localparam logic [15:0] V_MIN_HMV   = 16'h1770;
	localparam logic [15:0] V_MAX_HMV   = 16'h5dc0;
	localparam logic [15:0] V_PING_HMV  = 16'h32c8;
	localparam logic [15:0] V_RESET_HMV = 16'h1770;

	// ----------------------------------------
	// Loop constants, feedback LSB is one millivolt
	// ----------------------------------------
	localparam int          KP_GAIN           = 1;
	localparam logic [17:0] LOOP_OUTPUT_LIMIT = 18'h005dc;
	localparam int          SV_HMV_PER_UNIT   = -1;

	// ----------------------------------------
	// Operating frequency in kHz, and signal strength acceptance threshold
	// ----------------------------------------
	localparam logic [7:0] F_PING_KHZ  = 8'h8c;
	localparam logic [7:0] F_MIN_KHZ   = 8'h69;
	localparam logic [7:0] F_STEP_KHZ  = 8'h05;
	localparam logic [7:0] SS_ACCEPT   = 8'h10;

	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PING,
		ST_WAIT_SS,
		ST_REMOVE,
		ST_TRANSFER,
		ST_FAIL
	} itvc_state_type;
endpackage

// >>> hw/itvc_pid.sv
// One proportional loop step on the inverter supply setpoint
`timescale 1ns/1ps
module itvc_pid (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        load,
	input  wire logic        step,
	input  wire logic [15:0] target_mv,
	input  wire logic [15:0] meas_mv,
	output logic      [15:0] vset
);
	// ----------------------------------------
	// Error, gain and output clamp
	// ----------------------------------------
	wire logic signed [17:0] err;
	wire logic signed [17:0] lim_pos;
	wire logic signed [17:0] lim_neg;
	wire logic signed [17:0] pid_out;
	wire logic signed [19:0] sum;
	wire logic        [15:0] vset_nxt;

	assign err     = 18'(signed'({2'b00, target_mv})) - 18'(signed'({2'b00, meas_mv}));
	assign lim_pos = signed'(itvc_pkg::LOOP_OUTPUT_LIMIT);
	assign lim_neg = -lim_pos;
	// Gains Ki and Kd are zero, so no integrator or history is kept
	assign pid_out = (err > lim_pos) ? lim_pos : (err < lim_neg) ? lim_neg : err; // see RL9
	// Negative scaling: one output unit lowers the setpoint by half a millivolt
	assign sum     = 20'(signed'({4'h0, vset})) + 20'(pid_out) * 20'(itvc_pkg::SV_HMV_PER_UNIT); // see RL11
	assign vset_nxt = (sum < 20'(signed'({4'h0, itvc_pkg::V_MIN_HMV}))) ? itvc_pkg::V_MIN_HMV :
	                  (sum > 20'(signed'({4'h0, itvc_pkg::V_MAX_HMV}))) ? itvc_pkg::V_MAX_HMV :
	                  sum[15:0]; // see RL1

	// ----------------------------------------
	// Setpoint register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			vset <= itvc_pkg::V_RESET_HMV;
		else if (load)
			vset <= itvc_pkg::V_PING_HMV; // see RL3
		else if (step)
			vset <= vset_nxt; // see RL2, RL7
	end
endmodule

// >>> hw/itvc_align.sv
// Alignment indicator driven from the reported signal strength
`timescale 1ns/1ps
module itvc_align (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       enable,
	input  wire logic       ss_valid,
	input  wire logic [7:0] ss_value,
	output logic      [2:0] bar_level,
	output logic            aligned
);
	// ----------------------------------------
	// Distance bar and placement flag
	// ----------------------------------------
	wire logic [2:0] bar_nxt;
	wire logic       ok_nxt;

	assign bar_nxt = ss_value[7:5];
	assign ok_nxt  = (ss_value >= itvc_pkg::SS_ACCEPT);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bar_level <= 3'h0;
			aligned   <= 1'b0;
		end else if (!enable) begin
			bar_level <= 3'h0;
			aligned   <= 1'b0;
		end else if (ss_valid) begin
			bar_level <= bar_nxt; // see RL10
			aligned   <= ok_nxt; // see RL10
		end
	end
endmodule

// >>> dv/itvc_rx_model.sv
// Power receiver model answering each ping with one strength packet
`timescale 1ns/1ps
module itvc_rx_model (
	input  wire logic       clk,
	input  wire logic       power_en,
	input  wire logic       answer,
	input  wire logic [4:0] lag,
	input  wire logic [7:0] value,
	output logic            ss_valid,
	output logic      [7:0] ss_value
);
	logic [4:0] cnt_r = 5'h00;
	logic       on_r  = 1'b0;
	initial ss_valid = 1'b0;
	initial ss_value = 8'h00;
	// Between packets the value lines keep toggling, never a stale match
	always @(posedge clk) begin
		on_r     <= power_en;
		ss_valid <= 1'b0;
		ss_value <= ~ss_value;
		if (power_en && !on_r)
			cnt_r <= lag;
		else if (cnt_r != 5'h00)
			cnt_r <= cnt_r - 5'h01;
		if (cnt_r == 5'h01 && answer && power_en) begin
			ss_valid <= 1'b1;
			ss_value <= value;
		end
	end
endmodule

// >>> dv/itvc_chk.sv
// Port checker for the voltage controller
`timescale 1ns/1ps
module itvc_chk #(
	parameter int PW = 20
) (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        ss_valid,
	input wire logic [7:0]  ss_value,
	input wire logic        meas_valid,
	input wire logic [15:0] meas_mv,
	input wire logic [15:0] target_mv,
	input wire logic        power_en,
	input wire logic [7:0]  freq_khz,
	input wire logic [15:0] vset_hmv,
	input wire logic        transfer,
	input wire logic [2:0]  bar_level,
	input wire logic        aligned
);
	localparam int LIM = int'(itvc_pkg::LOOP_OUTPUT_LIMIT);
	int d_c;
	int e_c;
	int on_r;
	function automatic int sat(int v);
		return v < 6000 ? 6000 : (v > 24000 ? 24000 : v);
	endfunction
	assign d_c = int'(target_mv) - int'(meas_mv);
	assign e_c = d_c > LIM ? LIM : (d_c < -LIM ? -LIM : d_c);
	// Cycles with power on but no transfer, bounds a silent ping
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			on_r <= 0;
		else
			on_r <= (power_en && !transfer) ? on_r + 1 : 0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_vset_span: assert property (vset_hmv >= 16'h1770 && vset_hmv <= 16'h5dc0)
		else $error("setpoint out of range");
	a_ping_volt: assert property ($rose(power_en) |-> vset_hmv == 16'h32c8)
		else $error("ping voltage wrong");
	a_freq_move: assert property ($changed(freq_khz) |->
		freq_khz == $past(freq_khz) - 8'h05 || freq_khz == 8'h8c)
		else $error("bad frequency move");
	a_freq_span: assert property (freq_khz >= 8'h69 && freq_khz <= 8'h8c)
		else $error("frequency out of range");
	a_ping_off: assert property (on_r <= PW + 3)
		else $error("ping power not removed");
	a_accept_ss: assert property ($rose(transfer) |->
		$past(ss_valid) && $past(ss_value) >= 8'h10)
		else $error("transfer without good packet");
	a_step_cause: assert property ($changed(vset_hmv) && transfer && $past(transfer) |->
		$past(meas_valid, 2))
		else $error("setpoint moved without sample");
	a_step_value: assert property ($changed(vset_hmv) && transfer && $past(transfer) |->
		int'(vset_hmv) == sat(int'($past(vset_hmv)) - $past(e_c, 2)))
		else $error("setpoint step wrong");
	a_ind_off: assert property (!power_en && !$past(power_en) |->
		bar_level == 3'h0 && !aligned)
		else $error("indicator on while idle");
endmodule
bind itvc_top itvc_chk #(.PW(PING_WAIT_CYC)) chk_u (.clk(clk), .rstn(rstn),
	.ss_valid(ss_valid), .ss_value(ss_value), .meas_valid(meas_valid), .meas_mv(meas_mv),
	.target_mv(target_mv), .power_en(power_en), .freq_khz(freq_khz), .vset_hmv(vset_hmv),
	.transfer(transfer), .bar_level(bar_level), .aligned(aligned));

// >>> dv/testbench.sv
// Self-checking bench for the voltage controller
`timescale 1ns/1ps
module testbench;
	localparam int PW = 20;
	logic        clk = 1'b0;
	logic        rstn, start, stop, meas_valid, answer, ss_valid, power_en, transfer;
	logic        ping_fail, aligned;
	logic [4:0]  lag;
	logic [7:0]  value, ss_value, freq_khz;
	logic [15:0] meas_mv, target_mv, vset_hmv;
	logic [2:0]  bar_level;
	int          n_fail = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          vexp, n, k, t, m;
	always #2 clk = ~clk;
	itvc_top #(.PING_WAIT_CYC(PW), .REMOVE_OFF_CYC(10), .MAX_RETRIES(8)) dut_u (.clk(clk),
		.rstn(rstn), .start(start), .stop(stop), .ss_valid(ss_valid), .ss_value(ss_value),
		.meas_valid(meas_valid), .meas_mv(meas_mv), .target_mv(target_mv),
		.power_en(power_en), .freq_khz(freq_khz), .vset_hmv(vset_hmv), .transfer(transfer),
		.ping_fail(ping_fail), .bar_level(bar_level), .aligned(aligned));
	itvc_rx_model rx_u (.clk(clk), .power_en(power_en), .answer(answer), .lag(lag),
		.value(value), .ss_valid(ss_valid), .ss_value(ss_value));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wait_sig(input logic sel, input logic lvl, output int c);
		for (c = 0; c < 200 && (sel ? transfer : power_en) !== lvl; c++)
			@(negedge clk);
		// A wait that runs out counts as a mismatch
		if (c == 200)
			n_fail++;
	endtask
	// Model of one loop step: error clamped to 1500, scaled by minus half a millivolt
	task step(input int tv, input int mv, input logic live);
		int e;
		target_mv = 16'(tv);
		meas_mv = 16'(mv);
		meas_valid = 1'b1;
		@(negedge clk);
		meas_valid = 1'b0;
		repeat (2) @(negedge clk);
		e = tv - mv;
		e = e > 1500 ? 1500 : (e < -1500 ? -1500 : e);
		if (live)
			vexp = vexp - e < 6000 ? 6000 : (vexp - e > 24000 ? 24000 : vexp - e);
		chk(vset_hmv, 32'(vexp));
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_fail++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{rstn, start, stop, meas_valid, answer} = 5'h00;
		{lag, value, meas_mv, target_mv} = 45'h0;
		void'($urandom(32'heed6df46));
		repeat (12) @(negedge clk);
		chk(vset_hmv, 32'(itvc_pkg::V_RESET_HMV));
		chk(freq_khz, 32'h8c);
		rstn = 1'b1;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (k = 0; k < 8; k++) begin
			wait_sig(0, 1, n);
			chk(vset_hmv, 32'h32c8);
			chk(freq_khz, 32'(140 - 5 * k));
			wait_sig(0, 0, n);
			chk(n >= PW && n <= PW + 3, 1);
		end
		repeat (PW) @(negedge clk);
		chk(ping_fail, 1);
		answer = 1'b1;
		lag = 5'h03;
		value = 8'h0f;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		wait_sig(0, 1, n);
		wait_sig(0, 0, n);
		chk(transfer, 0);
		value = 8'h10 | 8'($urandom);
		lag = 5'h0f;
		wait_sig(1, 1, n);
		chk(freq_khz, 32'h87);
		chk(ping_fail, 0);
		repeat (2) @(negedge clk);
		chk(aligned, 1);
		chk(bar_level, value[7:5]);
		vexp = 13000;
		step(100, 3000, 0);
		repeat (itvc_pkg::SETTLE_CYC) @(negedge clk);
		for (k = 0; k < 40; k++) begin
			// Two single-step rises off the floor show the half-millivolt grain
			t = (k >= 10 && k < 24) ? 5000 : 0;
			m = k < 10 ? 5000 : (k > 23);
			if (k > 25) begin
				t = $urandom_range(4000);
				m = $urandom_range(4000);
			end
			step(t, m, 1);
		end
		stop = 1'b1;
		@(negedge clk);
		stop = 1'b0;
		wait_sig(0, 0, n);
		chk(transfer, 0);
		// An abort during a retry ping must not resume the retries
		repeat (PW) @(negedge clk);
		answer = 1'b0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		wait_sig(0, 1, n);
		wait_sig(0, 0, n);
		wait_sig(0, 1, n);
		stop = 1'b1;
		@(negedge clk);
		stop = 1'b0;
		chk(power_en, 0);
		repeat (PW) @(negedge clk);
		chk(power_en, 0);
		chk(freq_khz, 32'h87);
		chk(ping_fail, 0);
		end_of_test();
	end
endmodule
